/* File: verilog/sleep_regs.svh */
// Address map, field positions and reset values for the sleep and loopback block
`ifndef SLEEP_REGS_SVH
`define SLEEP_REGS_SVH

`define NUM_CHAN        8
`define CHAN_WIN_BITS   4
`define CFG_WIN_BASE    4'h8
`define ADDR_SUMMARY    8'h80
`define ADDR_SLEEP_EN   8'h8b
`define OFF_TX_HOLD     4'h0
`define OFF_INT_STATUS  4'h2
`define OFF_MODEM_CTRL  4'h4
`define LOOP_BIT        4
`define ISR_IDLE_BIT    0
`define SLEEP_EN_RST    8'h00
`define SLEEP_EN_ALL    8'hff
`define LOOP_EN_RST     8'h00
`define RDATA_RST       8'h00

`endif

/* File: verilog/sleep_pkg.sv */
// Types shared by the sleep and loopback block
package sleep_pkg;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE  = 3'b100
  } sleep_state_t;

  typedef struct packed {
    logic [7:0]   rx_s1;
    logic [7:0]   rx_s2;
    logic [31:0]  mdm_s1;
    logic [31:0]  mdm_s2;
    logic [31:0]  mdm_snap;
    logic [2:0]   bus_s1;
    logic [2:0]   bus_s2;
    logic [1:0]   act_q;
    logic [7:0]   addr_s1;
    logic [7:0]   addr_s2;
    logic [7:0]   data_s1;
    logic [7:0]   data_s2;
    logic [7:0]   sleep_en;
    logic [7:0]   loop_en;
    logic [7:0]   rdata;
    logic [7:0]   tx_q;
    logic [7:0]   rts_q;
    logic [7:0]   dtr_q;
    logic         wake_irq;
    sleep_state_t state;
  } sleep_regs_t;

endpackage

/* File: verilog/addr_decode.sv */
// Splits the 8-bit host address into channel windows and the configuration window
`include "sleep_regs.svh"

module addr_decode (
  input  wire logic [7:0] addr_in,
  output logic      [7:0] chan_sel_out,
  output logic            cfg_hit_out,
  output logic      [3:0] reg_off_out
);

  // ******************************************************************
  // Window decode
  // ******************************************************************

  function automatic logic is_cfg(input logic [7:0] a);
    is_cfg = (a[7:`CHAN_WIN_BITS] == `CFG_WIN_BASE);
  endfunction

  function automatic logic [7:0] chan_onehot(input logic [7:0] a);
    chan_onehot = 8'h00;
    if (a[7] == 1'b0)
    begin
      chan_onehot[a[6:4]] = 1'b1;
    end
  endfunction

  always_comb
  begin
    chan_sel_out = chan_onehot(addr_in); // (R18)
    cfg_hit_out  = is_cfg(addr_in);      // (R20)
    reg_off_out  = addr_in[3:0];         // (R17)
  end

endmodule

/* File: verilog/octal_uart_sleep.sv */
// Global sleep, wake-up, loopback routing and address decode of the octal UART
//
// Summary of operation
// (R1) Sleep only when no channel has interrupt pending
// (R2) Sleep only when sleep enable equals all ones
// (R3) Sleep only when all modem deltas are zero
// (R4) Sleep only when all receive inputs idle high
// (R5) Oscillator stopped while asleep
// (R6) Start bit on any receive input wakes
// (R7) Host transmit holding write wakes device
// (R8) Any modem input level change wakes device
// (R9) Every wake-up raises a host interrupt
// (R10) Wake interrupt cleared by interrupt status read
// (R11) Re-enter sleep once conditions hold again
// (R12) Host reads modem status to clear deltas
// (R13) Writing zero to sleep enable disarms sleep
// (R14) Modem control bit 4 selects channel loopback
// (R15) Loopback feeds transmit output into receiver
// (R16) Loopback: pins idle high, modem inputs ignored
// (R17) Eight-bit address, 256-byte register space
// (R18) Channel n owns sixteen bytes at n*0x10
// (R19) First eight channel registers are legacy layout
// (R20) Configuration registers at top, reached directly
// (R21) Sleep enable register holds one bit per channel
// (R22) Wake interrupt only after all channels slept
// (R23) Wake detection restarts oscillator without clock
`include "sleep_regs.svh"

module octal_uart_sleep (
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  // Host parallel bus
  input  wire logic [7:0]  addr_in,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe_out,
  input  wire logic        cs_n_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  output logic             irq_out,
  // Serial and modem pins, bit n is channel n
  input  wire logic [7:0]  rx_in,
  input  wire logic [7:0]  cts_n_in,
  input  wire logic [7:0]  dsr_n_in,
  input  wire logic [7:0]  cd_n_in,
  input  wire logic [7:0]  ri_n_in,
  output logic      [7:0]  tx_out,
  output logic      [7:0]  rts_n_out,
  output logic      [7:0]  dtr_n_out,
  output logic             osc_enable_out,
  // Channel cores
  input  wire logic [7:0]  chan_isr_idle_in,
  input  wire logic [31:0] chan_msr_delta_in,
  input  wire logic [7:0]  chan_rdata_in,
  input  wire logic [7:0]  chan_tx_in,
  input  wire logic [7:0]  chan_rts_n_in,
  input  wire logic [7:0]  chan_dtr_n_in,
  output logic      [7:0]  chan_sel_out,
  output logic      [3:0]  chan_reg_off_out,
  output logic      [7:0]  chan_wdata_out,
  output logic             chan_wr_out,
  output logic             chan_rd_out,
  output logic      [7:0]  chan_rx_out,
  output logic      [31:0] chan_modem_n_out,
  output logic             sleeping_out
);

  // ******************************************************************
  // Reset release
  // ******************************************************************

  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_sync_reg <= 2'b00;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ******************************************************************
  // Address decode
  // ******************************************************************

  sleep_pkg::sleep_regs_t st_reg;
  sleep_pkg::sleep_regs_t st_next;

  logic [7:0] dec_chan;
  logic       dec_cfg;
  logic [3:0] dec_off;

  addr_decode u_decode (
    .addr_in      (st_reg.addr_s2),
    .chan_sel_out (dec_chan),
    .cfg_hit_out  (dec_cfg),
    .reg_off_out  (dec_off)
  );

  // ******************************************************************
  // Bus strobes and wake terms
  // ******************************************************************

  logic        rd_act;
  logic        wr_act;
  logic        rd_evt;
  logic        wr_evt;
  logic        chan_hit;
  logic        enter_ok;
  logic        wake_seen;
  logic [31:0] mdm_raw;
  logic [31:0] loop_mask;

  function automatic logic [31:0] spread4(input logic [7:0] m);
    spread4 = {m, m, m, m};
  endfunction

  always_comb
  begin
    // bus_s2 = {cs_n, rd_n, wr_n}
    rd_act   = ~st_reg.bus_s2[2] & ~st_reg.bus_s2[1];
    wr_act   = ~st_reg.bus_s2[2] & ~st_reg.bus_s2[0];
    // Reads act on the leading edge, writes on the trailing edge
    rd_evt   = rd_act & ~st_reg.act_q[1];
    wr_evt   = ~wr_act & st_reg.act_q[0];
    chan_hit = |dec_chan;
    mdm_raw  = {ri_n_in, cd_n_in, dsr_n_in, cts_n_in};
    loop_mask = spread4(st_reg.loop_en);
    enter_ok = (&chan_isr_idle_in)                   // (R1)
             & (st_reg.sleep_en == `SLEEP_EN_ALL)     // (R2) (R13) (R22)
             & ~(|chan_msr_delta_in)                  // (R3) (R12)
             & (&st_reg.rx_s2)                        // (R4)
             & ~st_reg.wake_irq
             & ~wr_act
             & ~rd_act;
    wake_seen = ~(&st_reg.rx_s2)                                   // (R6)
              | ((st_reg.mdm_s2 & ~loop_mask)
                 != (st_reg.mdm_snap & ~loop_mask))                // (R8)
              | (wr_evt & chan_hit & (dec_off == `OFF_TX_HOLD))    // (R7)
              | (st_reg.sleep_en != `SLEEP_EN_ALL);                // (R13)
  end

  // ******************************************************************
  // Next state
  // ******************************************************************

  always_comb
  begin
    st_next = st_reg;

    st_next.rx_s1   = rx_in;
    st_next.rx_s2   = st_reg.rx_s1;
    st_next.mdm_s1  = mdm_raw;
    st_next.mdm_s2  = st_reg.mdm_s1;
    st_next.bus_s1  = {cs_n_in, rd_n_in, wr_n_in};
    st_next.bus_s2  = st_reg.bus_s1;
    st_next.act_q   = {rd_act, wr_act};
    st_next.addr_s1 = addr_in;
    st_next.addr_s2 = st_reg.addr_s1;
    st_next.data_s1 = data_in;
    st_next.data_s2 = st_reg.data_s1;

    // Configuration window writes
    if (wr_evt && dec_cfg && (st_reg.addr_s2 == `ADDR_SLEEP_EN))
    begin
      st_next.sleep_en = st_reg.data_s2; // (R21) (R13)
    end

    // Shadow of each channel's loopback bit, the channel core keeps the rest
    if (wr_evt && chan_hit && (dec_off == `OFF_MODEM_CTRL))
    begin
      for (int i = 0; i < `NUM_CHAN; i++)
      begin
        if (dec_chan[i])
        begin
          st_next.loop_en[i] = st_reg.data_s2[`LOOP_BIT]; // (R14)
        end
      end
    end

    // Read data is latched at the leading edge and held for the strobe
    if (rd_evt)
    begin
      if (dec_cfg)
      begin
        case (st_reg.addr_s2)
          `ADDR_SUMMARY:  st_next.rdata = ~chan_isr_idle_in; // (R20)
          `ADDR_SLEEP_EN: st_next.rdata = st_reg.sleep_en;   // (R21)
          default:        st_next.rdata = `RDATA_RST;
        endcase
      end
      else
      begin
        st_next.rdata = chan_rdata_in; // (R19)
      end
      if (chan_hit && (dec_off == `OFF_INT_STATUS))
      begin
        st_next.wake_irq = 1'b0; // (R10)
      end
    end

    // Loopback: pins idle inactive, receiver sees own transmitter
    st_next.tx_q  = chan_tx_in | st_reg.loop_en;    // (R16)
    st_next.rts_q = chan_rts_n_in | st_reg.loop_en; // (R16)
    st_next.dtr_q = chan_dtr_n_in | st_reg.loop_en; // (R16)

    case (st_reg.state)
      sleep_pkg::ST_RUN:
      begin
        if (enter_ok)
        begin
          st_next.state    = sleep_pkg::ST_SLEEP; // (R11)
          st_next.mdm_snap = st_reg.mdm_s2;
        end
      end
      sleep_pkg::ST_SLEEP:
      begin
        if (wake_seen)
        begin
          st_next.state = sleep_pkg::ST_WAKE;
        end
      end
      sleep_pkg::ST_WAKE:
      begin
        // Set after any clear above so a coincident INTERRUPT_STATUS_REG read cannot lose it
        st_next.wake_irq = 1'b1; // (R9) (R22)
        st_next.state    = sleep_pkg::ST_RUN;
      end
      default:
      begin
        st_next.state = sleep_pkg::ST_RUN;
      end
    endcase
  end

  // ******************************************************************
  // State register
  // ******************************************************************

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg          <= '0;
      st_reg.rx_s1    <= 8'hff;
      st_reg.rx_s2    <= 8'hff;
      st_reg.bus_s1   <= 3'h7;
      st_reg.bus_s2   <= 3'h7;
      st_reg.tx_q     <= 8'hff;
      st_reg.rts_q    <= 8'hff;
      st_reg.dtr_q    <= 8'hff;
      st_reg.sleep_en <= `SLEEP_EN_RST;
      st_reg.loop_en  <= `LOOP_EN_RST;
      st_reg.rdata    <= `RDATA_RST;
      st_reg.state    <= sleep_pkg::ST_RUN;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************

  // The oscillator gate must react while the clock is stopped, so the
  // raw pins are looked at here; a glitch only costs a brief restart.
  assign osc_enable_out = ~st_reg.state[1]                          // (R5)
                        | ~(&rx_in)                                  // (R23)
                        | ((mdm_raw & ~loop_mask) != (st_reg.mdm_snap & ~loop_mask))
                        | (~cs_n_in & ~wr_n_in);

  assign sleeping_out     = st_reg.state[1];
  assign data_out         = st_reg.rdata;
  assign data_oe_out      = rd_act;
  assign irq_out          = st_reg.wake_irq | ~(&chan_isr_idle_in); // (R9)
  assign tx_out           = st_reg.tx_q;
  assign rts_n_out        = st_reg.rts_q;
  assign dtr_n_out        = st_reg.dtr_q;
  assign chan_sel_out     = dec_chan;
  assign chan_reg_off_out = dec_off;
  assign chan_wdata_out   = st_reg.data_s2;
  assign chan_wr_out      = wr_evt & chan_hit;
  assign chan_rd_out      = rd_evt & chan_hit;
  assign chan_rx_out      = (st_reg.rx_s2 & ~st_reg.loop_en)
                          | (chan_tx_in & st_reg.loop_en);          // (R15)
  assign chan_modem_n_out = st_reg.mdm_s2 | loop_mask;              // (R16)

endmodule

/* File: dv/octal_uart_sleep_checker.sv */
// Port-level assertions for the sleep and loopback block
module octal_uart_sleep_checker (
  input wire logic        mclk_in,
  input wire logic        arst_n_in,
  input wire logic [7:0]  addr_in,
  input wire logic [7:0]  rx_in,
  input wire logic [7:0]  chan_isr_idle_in,
  input wire logic [31:0] chan_msr_delta_in,
  input wire logic [7:0]  chan_tx_in,
  input wire logic        irq_out,
  input wire logic [7:0]  tx_out,
  input wire logic        osc_enable_out,
  input wire logic [7:0]  chan_sel_out,
  input wire logic [3:0]  chan_reg_off_out,
  input wire logic        chan_wr_out,
  input wire logic        chan_rd_out,
  input wire logic        sleeping_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  // ****************
  // Assertions
  // ****************
  a_idle_before_sleep: assert property ($rose(sleeping_out) |-> $past(&chan_isr_idle_in))
    else $error("sleep entered with interrupt pending");
  a_delta_before_sleep: assert property ($rose(sleeping_out) |-> $past(chan_msr_delta_in) == 32'h0)
    else $error("sleep entered with modem delta set");
  a_osc_runs_awake: assert property (!sleeping_out |-> osc_enable_out)
    else $error("oscillator stopped while awake");
  a_rx_restarts_osc: assert property (sleeping_out && !(&rx_in) |-> osc_enable_out)
    else $error("oscillator held off with start bit present");
  a_rx_wakes: assert property (sleeping_out && !(&rx_in) |-> ##[1:4] !sleeping_out)
    else $error("start bit did not wake");
  a_thr_wakes: assert property (sleeping_out && chan_wr_out && chan_reg_off_out == 4'h0
    |-> ##[1:3] !sleeping_out)
    else $error("transmit write did not wake");
  a_wake_irq: assert property ($fell(sleeping_out) |-> ##[0:2] irq_out)
    else $error("no interrupt after wake");
  a_tx_mark: assert property (((~tx_out) & $past(chan_tx_in)) == 8'h00)
    else $error("transmit pin low without cause");
  a_rd_decode: assert property (chan_rd_out |-> chan_sel_out == (8'h01 << addr_in[6:4])
    && chan_reg_off_out == addr_in[3:0] && !addr_in[7])
    else $error("channel read decoded wrongly");
  a_wr_onehot: assert property (chan_wr_out |-> $onehot(chan_sel_out) && !addr_in[7])
    else $error("channel write without single channel");
  c_sleep: cover property ($rose(sleeping_out));
  c_wake: cover property ($fell(sleeping_out));
  c_wr: cover property (chan_wr_out && chan_reg_off_out == 4'h4);
endmodule

bind octal_uart_sleep octal_uart_sleep_checker chk_i (.mclk_in, .arst_n_in, .addr_in, .rx_in,
  .chan_isr_idle_in, .chan_msr_delta_in, .chan_tx_in, .irq_out, .tx_out, .osc_enable_out,
  .chan_sel_out, .chan_reg_off_out, .chan_wr_out, .chan_rd_out, .sleeping_out);

/* File: dv/host_bus_model.sv */
// Host processor model for the parallel register bus
module host_bus_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            cs_n_out,
  output logic            rd_n_out,
  output logic            wr_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rd_val;
  event       done;
  initial {addr_out, wdata_out, cs_n_out, rd_n_out, wr_n_out} = {16'h0, 3'b111};
  // Strobes held four edges and data kept four edges past release: two sync stages need three
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rd);
    @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    cs_n_out = 1'b0;
    rd_n_out = !rd;
    wr_n_out = rd;
    repeat (4) @(posedge clk_in);
    rd_val = rdata_in;
    #1;
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    if (rd)
      -> done;
    repeat (4) @(posedge clk_in);
    #1;
    wdata_out = ~d;
  endtask
endmodule

/* File: dv/tb_octal_uart_sleep.sv */
// Self-checking bench for the sleep, wake-up, loopback and address map logic
module tb_octal_uart_sleep;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, arst_n = 0, cs_n, rd_n, wr_n, irq, oe, osc, wr, rd, slp;
  logic [7:0] addr, wdata, rdata, rx = 8'hff, cts = 8'hff, dsr = 8'hff, cd = 8'hff, ri = 8'hff;
  logic [7:0] tx, rts, dtr, interrupt_status_reg = 8'hff, ctx = 8'h00, crts = 8'h00, cdtr = 8'h00, sel, crx, cwd;
  logic [31:0] modem_status_reg = 32'h0, mdm;
  logic [3:0] off;
  logic [7:0] q[$];
  int n_fail = 0, check_count = 0, seed = 32'h6d6d, ch;
  always #5 mclk = ~mclk;
  host_bus_model host_bus_model_i (.clk_in(mclk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n));
  octal_uart_sleep octal_uart_sleep_i (.mclk_in(mclk), .arst_n_in(arst_n), .addr_in(addr), .data_in(wdata),
    .data_out(rdata), .data_oe_out(oe), .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .irq_out(irq),
    .rx_in(rx), .cts_n_in(cts), .dsr_n_in(dsr), .cd_n_in(cd), .ri_n_in(ri), .tx_out(tx), .rts_n_out(rts),
    .dtr_n_out(dtr), .osc_enable_out(osc), .chan_isr_idle_in(interrupt_status_reg), .chan_msr_delta_in(modem_status_reg),
    .chan_rdata_in(sel ^ {4'h0, off}), .chan_tx_in(ctx), .chan_rts_n_in(crts), .chan_dtr_n_in(cdtr),
    .chan_sel_out(sel), .chan_reg_off_out(off), .chan_wdata_out(cwd), .chan_wr_out(wr), .chan_rd_out(rd),
    .chan_rx_out(crx), .chan_modem_n_out(mdm), .sleeping_out(slp));
  // Channel core stand-in: reading modem status clears its deltas
  always @(posedge mclk)
  begin
    if (rd && off == 4'h6)
      modem_status_reg <= 32'h0;
    if (wr && off == 4'h0)
      cmp(cwd, 8'h55);
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(host_bus_model_i.done)
    cmp({oe, host_bus_model_i.rd_val}, {1'b1, q.pop_front()});
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    host_bus_model_i.xfer(a, 8'h00, 1'b1);
  endtask
  function automatic logic [7:0] chan_val(input logic [7:0] a);
    return (8'h01 << a[6:4]) ^ {4'h0, a[3:0]};
  endfunction
  task automatic wait_lvl(input int w, input logic v);
    logic [1:0] s;
    for (int i = 0; i < 60; i++)
    begin
      @(posedge mclk);
      #1;
      s = {irq, slp};
      if (s[w] === v)
        return;
    end
    n_fail++;
    $display("CHECK FAILED %0t: wait ran out", $time);
    finish_test();
  endtask
  task automatic block(input int i, input logic b);
    case (i)
      0: interrupt_status_reg = b ? 8'hfe : 8'hff;
      1: modem_status_reg = b ? 32'h10 : 32'h0;
      2: rx = b ? 8'hef : 8'hff;
      default: host_bus_model_i.xfer(8'h8b, b ? 8'h7f : 8'hff, 1'b0);
    endcase
  endtask
  initial
  begin
    logic [7:0] a;
    interrupt_status_reg = 8'($random(seed));
    repeat (20) @(posedge mclk);
    #1 arst_n = 1;
    repeat (3) @(posedge mclk);
    rd_chk(8'h8b, 8'h00);
    rd_chk(8'h80, ~interrupt_status_reg);
    rd_chk(8'h8c, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      a = {1'b0, i[2:0], 4'(($random(seed)))};
      rd_chk(a, chan_val(a));
    end
    $display("map test done");
    block(0, 1);
    host_bus_model_i.xfer(8'h8b, 8'hff, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      repeat (15) @(posedge mclk);
      #1 cmp(slp, 1'b0);
      if (i < 3)
        block(i + 1, 1);
      // The next blocker must reach the synced side before the old one lifts
      repeat (3) @(posedge mclk);
      #1 block(i, 0);
    end
    wait_lvl(0, 1);
    cmp(osc, 1'b0);
    rd_chk(8'h8b, 8'hff);
    $display("entry test done");
    for (int k = 0; k < 6; k++)
    begin
      ch = {$random(seed)} % 8;
      ctx = 8'($random(seed));
      crts = 8'($random(seed));
      cdtr = 8'($random(seed));
      case (k)
        0: rx[ch] = 1'b0;
        1: cts[ch] = ~cts[ch];
        2: dsr[ch] = ~dsr[ch];
        3: cd[ch] = ~cd[ch];
        4: ri[ch] = ~ri[ch];
        default: host_bus_model_i.xfer(8'(ch * 16), 8'h55, 1'b0);
      endcase
      #1 cmp(osc, 1'b1);
      if (k > 0 && k < 5)
        modem_status_reg[4 * ch + k - 1] = 1'b1;
      wait_lvl(0, 0);
      wait_lvl(1, 1);
      rx = 8'hff;
      if (k > 0 && k < 5)
        rd_chk(8'(ch * 16 + 6), chan_val(8'(ch * 16 + 6)));
      rd_chk(8'(ch * 16 + 2), chan_val(8'(ch * 16 + 2)));
      wait_lvl(1, 0);
      wait_lvl(0, 1);
    end
    $display("wake test done");
    host_bus_model_i.xfer(8'h8b, 8'h00, 1'b0);
    wait_lvl(0, 0);
    rd_chk(8'h22, chan_val(8'h22));
    repeat (20) @(posedge mclk);
    #1 cmp(slp, 1'b0);
    $display("disarm test done");
    host_bus_model_i.xfer(8'(ch * 16 + 4), 8'h10, 1'b0);
    for (int b = 0; b < 2; b++)
    begin
      ctx[ch] = b[0];
      cts[ch] = b[0];
      repeat (4) @(posedge mclk);
      #1 cmp(crx[ch], b[0]);
      cmp({tx[ch], rts[ch], dtr[ch], mdm[ch]}, 4'hf);
    end
    host_bus_model_i.xfer(8'(ch * 16 + 4), 8'h00, 1'b0);
    cts[ch] = 1'b0;
    ctx[ch] = 1'b0;
    repeat (4) @(posedge mclk);
    #1 cmp({tx[ch], rts[ch], dtr[ch], mdm[ch], crx[ch]}, {1'b0, crts[ch], cdtr[ch], 1'b0, rx[ch]});
    $display("loopback test done");
    finish_test();
  end
endmodule
